//--- verilog/pmc_top.v
// pmc_top.v: pin level supervisory logic of the power manager
// assumes pins are asynchronous; config/status bits are plain ports
`include "pmc_map.vh"
`default_nettype none
module pmc_top #(
  parameter CB_PULSE_CYC = `PMC_CB_PULSE_CYC  // crowbar pulse length in cycles
) (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // supervisory pins, active low
  input  wire        mains_fail_in_n,
  input  wire        soft_shutdown_in_n,
  input  wire        cold_reset_in_n,
  input  wire [3:0]  remote_enable_in_n,
  // address straps
  input  wire        host_addr_strap_0,
  input  wire        host_addr_strap_1,
  input  wire        host_addr_strap_2,
  // group ok open-drain lines, a..d in bits 0..3
  input  wire [3:0]  group_ok_line_in,
  output reg  [3:0]  group_ok_line_out,
  output reg  [3:0]  group_ok_line_oe,
  // sync/data open-drain line
  input  wire        sync_data_line_in,
  output reg         sync_data_line_out,
  output reg         sync_data_line_oe,
  // bus voltage sense sample from the converter
  input  wire [9:0]  bus_voltage_sense,
  // configuration
  input  wire [15:0] int_group_map,
  input  wire        auto_turn_on,
  input  wire [9:0]  ovp_threshold,
  input  wire [3:0]  group_force_off,
  input  wire        tx_bit,
  // outputs and status
  output reg         front_end_enable,
  output reg         crowbar_trigger,
  output reg  [6:0]  host_addr,
  output reg  [3:0]  group_enable,
  output reg  [3:0]  group_fault,
  output reg  [9:0]  intermediate_bus_voltage,
  output reg         rx_bit,
  output reg         rx_strobe,
  output reg  [3:0]  seq_state
);
  localparam ST_OFF  = `PMC_ST_OFF;
  localparam ST_RUN  = `PMC_ST_RUN;
  localparam ST_SHUT = `PMC_ST_SHUT;
  localparam ST_HOLD = `PMC_ST_HOLD;

  wire [8:0] raw_in;       // ok line, remote enable and mains pins, one debouncer each
  wire [8:0] flt;          // filtered levels
  wire       mains_ok;     // mains present
  wire       soft_rel;     // soft shutdown released
  wire       cold_n;       // filtered cold reset
  wire [3:0] int_rel;      // interrupt inputs released
  wire [3:0] ok_hi;        // ok lines high
  reg  [1:0] cold_q;       // cold reset held-state pipe
  reg  [3:0] int_off;      // groups held off by interrupts
  reg  [1:0] seq_idx;      // group index for sequenced turn-off
  reg  [31:0] cb_cnt;      // crowbar pulse counter
  reg  [7:0] sd_cnt;       // sync/data period counter
  reg        sd_bit;       // bit latched for this period
  reg        sd_a;         // sync/data first stage
  reg        sd_b;         // sync/data second stage
  reg  [2:0] strap_a;      // strap first stage
  reg  [2:0] strap_b;      // strap second stage
  reg        strap_taken;  // address latched after release
  integer    g;            // loop index

  // our own pull is masked before the filter: a line we release would
  // otherwise read low for a whole filter time and look like a fault
  assign raw_in = {group_ok_line_in | group_ok_line_oe, remote_enable_in_n,
                   mains_fail_in_n} ;

  // one filter per pin
  genvar i;
  generate
    for (i = 0; i < 9; i = i + 1) begin : g_deb
      pmc_debounce u_deb (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (raw_in[i]),
        .level  (flt[i])
      );
    end
  endgenerate

  pmc_debounce u_deb_soft (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (soft_shutdown_in_n),
    .level  (soft_rel)
  );

  pmc_debounce u_deb_cold (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (cold_reset_in_n),
    .level  (cold_n)
  );

  assign mains_ok = flt[0];
  assign int_rel  = flt[4:1];
  assign ok_hi    = flt[8:5];

  // cold reset: a filtered low restarts the sequencer and strap sampling and blocks a new crowbar pulse; a running pulse, sense and sync/data logic run on
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cold_q <= 2'b00;
    end else begin
      cold_q <= {cold_q[0], cold_n};
    end
  end

  // strap address sampled through two flops once after reset release
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_a     <= 3'h7;
      strap_b     <= 3'h7;
      strap_taken <= 1'b0;
      host_addr   <= 7'h50;
    end else begin
      strap_a <= {host_addr_strap_2, host_addr_strap_1, host_addr_strap_0};
      strap_b <= strap_a;
      if (!cold_q[1]) begin
        strap_taken <= 1'b0;  // resample after a cold start
      end else if (!strap_taken) begin
        strap_taken <= 1'b1;
        host_addr   <= {3'h5, strap_b, 1'b0};
      end
    end
  end

  // power sequencer, interrupt gating, ok line sensing and driving
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_state         <= ST_OFF;
      seq_idx           <= 2'h0;
      front_end_enable  <= 1'b0;
      group_enable      <= 4'h0;
      int_off           <= 4'h0;
      group_fault       <= 4'h0;
      group_ok_line_out <= 4'h0;
      group_ok_line_oe  <= 4'h0;
    end else if (!cold_q[1]) begin
      seq_state         <= ST_OFF;
      seq_idx           <= 2'h0;
      front_end_enable  <= 1'b0;
      group_enable      <= 4'h0;
      int_off           <= 4'h0;
      group_fault       <= 4'h0;
      group_ok_line_oe  <= 4'h0;
    end else begin
      // each held interrupt forces its mapped groups off
      for (g = 0; g < 4; g = g + 1) begin
        int_off[g] <= (!int_rel[0] & int_group_map[g])
                    | (!int_rel[1] & int_group_map[4 + g])
                    | (!int_rel[2] & int_group_map[8 + g])
                    | (!int_rel[3] & int_group_map[12 + g]);
      end
      // a low ok line we are not driving ourselves is a fault report
      group_fault <= ~ok_hi & ~group_ok_line_oe;
      group_ok_line_out <= 4'h0;
      group_ok_line_oe  <= group_force_off | ~group_enable;
      case (seq_state)
        ST_OFF: begin
          front_end_enable <= 1'b0;
          group_enable     <= 4'h0;
          if (mains_ok && soft_rel && auto_turn_on && !crowbar_trigger) begin
            seq_state <= ST_RUN;
          end
        end
        ST_RUN: begin
          front_end_enable <= 1'b1;
          group_enable     <= ~int_off;
          if (!mains_ok || crowbar_trigger) begin
            seq_state    <= ST_HOLD;
            group_enable <= 4'h0;
          end else if (!soft_rel) begin
            seq_state <= ST_SHUT;
            seq_idx   <= 2'h3;
          end
        end
        ST_SHUT: begin
          group_enable[seq_idx] <= 1'b0;
          if (!mains_ok) begin
            seq_state <= ST_HOLD;
          end else if (seq_idx == 2'h0) begin
            seq_state <= ST_HOLD;
          end else begin
            seq_idx <= seq_idx - 2'h1;
          end
        end
        ST_HOLD: begin
          group_enable     <= 4'h0;
          front_end_enable <= 1'b0;
          if (mains_ok && soft_rel) begin
            seq_state <= ST_OFF;
          end
        end
        default: begin
          seq_state <= ST_OFF;
        end
      endcase
    end
  end

  // sense sampling and crowbar pulse
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intermediate_bus_voltage <= 10'h000;
      crowbar_trigger          <= 1'b0;
      cb_cnt                   <= 32'h0;
    end else begin
      intermediate_bus_voltage <= bus_voltage_sense;
      if (crowbar_trigger) begin
        if (cb_cnt == CB_PULSE_CYC - 1) begin
          crowbar_trigger <= 1'b0;
        end else begin
          cb_cnt <= cb_cnt + 32'h1;
        end
      end else if (bus_voltage_sense > ovp_threshold && cold_q[1]) begin
        crowbar_trigger <= 1'b1;
        cb_cnt          <= 32'h0;
      end
    end
  end

  // sync/data master clock: low pulse each period, long for a zero
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sd_cnt             <= 8'h00;
      sd_bit             <= 1'b1;
      sd_a               <= 1'b1;
      sd_b               <= 1'b1;
      sync_data_line_out <= 1'b0;
      sync_data_line_oe  <= 1'b0;
      rx_bit             <= 1'b1;
      rx_strobe          <= 1'b0;
    end else begin
      sd_a      <= sync_data_line_in;
      sd_b      <= sd_a;
      rx_strobe <= 1'b0;
      sync_data_line_out <= 1'b0;
      if (sd_cnt == `PMC_SD_PERIOD_CYC - 8'h01) begin
        sd_cnt <= 8'h00;
        sd_bit <= tx_bit;
      end else begin
        sd_cnt <= sd_cnt + 8'h01;
      end
      sync_data_line_oe <= (sd_cnt < `PMC_SD_SYNC_CYC)
                         | (!sd_bit & (sd_cnt < `PMC_SD_ZERO_CYC));
      if (sd_cnt == `PMC_SD_SAMPLE_CYC) begin
        rx_bit    <= sd_b;
        rx_strobe <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- inc/pmc_map.vh
// pmc_map.vh: constants for the power manager control pin block
// assumes a 125 MHz core clock and an 8 ns period
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// clock rate in kHz
`define PMC_CLK_KHZ        125000
// crowbar pulse length in microseconds and its cycle count
`define PMC_CB_PULSE_US    1000
`define PMC_CB_PULSE_CYC   ((`PMC_CB_PULSE_US * `PMC_CLK_KHZ) / 1000)
// debounce filter length in cycles
`define PMC_DEB_CYC        8'h10
// sync/data clock: 500 kHz, 250 cycles per period
`define PMC_SD_PERIOD_CYC  8'hfa
// sync pulse low 25 percent, data zero low 75 percent of the period
`define PMC_SD_SYNC_CYC    8'h3e
`define PMC_SD_ZERO_CYC    8'hbb
// point in the period where a returned bit is sampled
`define PMC_SD_SAMPLE_CYC  8'h7d
// width of the sense sample word
`define PMC_ADC_W          10
// number of converter groups and remote enable inputs
`define PMC_NGRP           4
`define PMC_NINT           4
// sequencer states, one-hot
`define PMC_ST_OFF         4'h1
`define PMC_ST_RUN         4'h2
`define PMC_ST_SHUT        4'h4
`define PMC_ST_HOLD        4'h8

`endif

//--- verilog/pmc_debounce.v
// pmc_debounce.v: two-flop synchroniser plus stable-count filter
// assumes the input is asynchronous to clk; output resets high (idle)
`include "pmc_map.vh"
`default_nettype none
module pmc_debounce (
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  // raw pin and filtered level
  input  wire pin,
  output reg  level
);
  reg       sync_a;  // first synchroniser stage
  reg       sync_b;  // second synchroniser stage
  reg [7:0] cnt;     // cycles the new value has stood

  // synchronise, then accept a change only after it stands long enough
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      cnt    <= 8'h00;
      level  <= 1'b1;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      if (sync_b == level) begin
        cnt <= 8'h00;  // no change pending
      end else if (cnt == `PMC_DEB_CYC) begin
        level <= sync_b;  // change has been stable
        cnt   <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/pmc_checker.sv
// pmc_checker.sv: timing checks on the power manager pins
// assumes it is bound into pmc_top and sees one clock domain
`default_nettype none
module pmc_checker #(
  parameter CB_PULSE_CYC = 50  // crowbar pulse length in cycles
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // watched inputs
  input wire logic       mains_fail_in_n,
  input wire logic       soft_shutdown_in_n,
  input wire logic [9:0] bus_voltage_sense,
  input wire logic [9:0] ovp_threshold,
  input wire logic [3:0] group_force_off,
  // watched outputs
  input wire logic [3:0] group_ok_line_out,
  input wire logic [3:0] group_ok_line_oe,
  input wire logic       sync_data_line_out,
  input wire logic       sync_data_line_oe,
  input wire logic       crowbar_trigger,
  input wire logic [6:0] host_addr,
  input wire logic [3:0] seq_state,
  input wire logic       front_end_enable,
  input wire logic [9:0] intermediate_bus_voltage
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  int cb_cnt;   // cycles the crowbar has stood high
  int sd_cnt;   // cycles the sync line has been pulled
  int low_cnt;  // cycles a shutdown pin has been held low
  // helper counters, cleared whenever their cause drops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cb_cnt <= 0;
      sd_cnt <= 0;
      low_cnt <= 0;
    end else begin
      cb_cnt <= crowbar_trigger ? cb_cnt + 1 : 0;
      sd_cnt <= sync_data_line_oe ? sd_cnt + 1 : 0;
      low_cnt <= (!mains_fail_in_n || !soft_shutdown_in_n) ? low_cnt + 1 : 0;
    end
  end
  cb_width_a: assert property (
    $fell(crowbar_trigger) |-> cb_cnt == CB_PULSE_CYC) else $error("crowbar pulse length");
  cb_fire_a: assert property (
    bus_voltage_sense > ovp_threshold |-> ##[1:2] crowbar_trigger) else $error("crowbar missed");
  sd_pulse_a: assert property (
    $fell(sync_data_line_oe) |-> sd_cnt == 62 || sd_cnt == 187) else $error("sync pulse length");
  od_low_a: assert property (
    !sync_data_line_out && group_ok_line_out == 4'h0) else $error("open drain drives high");
  force_ok_a: assert property (
    group_force_off[2] [*3] |-> group_ok_line_oe[2]) else $error("ok line not pulled");
  shut_seq_a: assert property (
    seq_state == 4'h4 |-> ##[1:8] seq_state == 4'h8) else $error("shutdown too slow");
  pin_stop_a: assert property (
    low_cnt == 30 |-> seq_state != 4'h2) else $error("still running");
  glitch_a: assert property (
    $rose(seq_state == 4'h4) |-> low_cnt >= 16) else $error("shutdown on glitch");
  addr_form_a: assert property (
    host_addr[6:4] == 3'h5 && !host_addr[0]) else $error("address form");
  fe_on_a: assert property (
    seq_state == 4'h2 && $past(seq_state) == 4'h2 |-> front_end_enable)
    else $error("front end not on");
  fe_off_a: assert property (
    seq_state == 4'h8 |=> !front_end_enable) else $error("front end not off");
  sense_copy_a: assert property (
    intermediate_bus_voltage == $past(bus_voltage_sense)) else $error("sense not sampled");
endmodule
`default_nettype wire

//--- verif/pmc_pol_model.sv
// pmc_pol_model.sv: converters on the sync line answering alternate bits
// assumes a pulled-up line that the device pulls low to start each period
`default_nettype none
module pmc_pol_model (
  // link sampling clock
  input  wire logic lclk,
  // resolved line and the model's pull
  input  wire logic line,
  output var  logic pull,
  output var  logic reply
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold;  // link cycles left in a stretched low
  logic       last;  // line level at the previous link edge
  initial begin
    pull = 1'b0;
    reply = 1'b1;
    hold = 4'h0;
    last = 1'b1;
  end
  // lock to each sync fall; a zero answer stretches the low past the sample point
  always @(posedge lclk) begin
    last <= line;
    if (hold != 4'h0) begin
      hold <= hold - 4'h1;
      if (hold == 4'h1) pull <= 1'b0;
    end else if (last && !line) begin
      reply <= ~reply;
      pull <= reply;
      hold <= 4'h8;
    end
  end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// testbench.sv: drives the power manager pins and scores the results
// assumes pmc_top, pmc_checker and pmc_pol_model are compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CB_PULSE_CYC = 50;  // shortened crowbar pulse
  logic clk = 0, lclk = 0, arst_n = 0, mains_fail_in_n = 1, soft_shutdown_in_n = 1;
  logic cold_reset_in_n = 1, auto_turn_on = 1, tx_bit = 1, crowbar_trigger, rx_bit, rx_strobe;
  logic sync_data_line_oe, pull, reply, host_addr_strap_0, host_addr_strap_1, host_addr_strap_2;
  logic [3:0] remote_enable_in_n = 4'hf, group_force_off = 0, ok_pull = 0, group_ok_line_oe;
  logic [3:0] group_enable, group_fault, seq_state;
  logic [9:0] bus_voltage_sense = 0, ovp_threshold = 10'h3ff;
  logic [15:0] int_group_map = 0;
  logic [6:0] host_addr;
  logic [2:0] s;
  logic [47:0] q[$];  // mask and expected value per check
  logic [23:0] nm, ne;  // mask and expected value taken off the queue
  logic tx_sent;  // bit the device sends in the current sync period
  int ph;  // cycle within the 250-cycle sync period
  int seed, err_total, total_checks;
  event look;
  wire [3:0] group_ok_line_in = ~(group_ok_line_oe | ok_pull);  // pulled-up lines
  wire sync_data_line_in = ~(sync_data_line_oe | pull);
  wire [23:0] probe = {crowbar_trigger, seq_state, group_enable, host_addr, group_fault,
                       group_ok_line_oe};
  always #4 clk = ~clk;
  initial #3 forever #80 lclk = ~lclk;
  assign {host_addr_strap_2, host_addr_strap_1, host_addr_strap_0} = s;
  pmc_top #(.CB_PULSE_CYC(CB_PULSE_CYC)) pmc_top_inst (.clk, .arst_n, .mains_fail_in_n,
    .soft_shutdown_in_n, .cold_reset_in_n, .remote_enable_in_n, .host_addr_strap_0,
    .host_addr_strap_1, .host_addr_strap_2, .group_ok_line_in, .group_ok_line_out(),
    .group_ok_line_oe, .sync_data_line_in, .sync_data_line_out(), .sync_data_line_oe,
    .bus_voltage_sense, .int_group_map, .auto_turn_on, .ovp_threshold, .group_force_off,
    .tx_bit, .front_end_enable(), .crowbar_trigger, .host_addr, .group_enable, .group_fault,
    .intermediate_bus_voltage(), .rx_bit, .rx_strobe, .seq_state);
  pmc_pol_model pmc_pol_model_inst (.lclk, .line(sync_data_line_in), .pull, .reply);
  // compare and count
  task check(input string n, input [23:0] v, input [23:0] e);
    total_checks++;
    if (v !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task expect_pins(input [23:0] m, input [23:0] e);
    q.push_back({m, e});
    -> look;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // scoreboard: oldest note against the pins
  always @(look) begin
    {nm, ne} = q.pop_front();
    check("pins", probe & nm, ne);
  end
  // reference sync period: the next bit is taken at the period's last cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph <= 0;
      tx_sent <= 1'b1;
    end else begin
      ph <= (ph == 249) ? 0 : ph + 1;
      if (ph == 249) tx_sent <= tx_bit;
    end
  end
  // a sent zero holds the line low past the sample point, so only ones carry the reply
  always @(negedge clk)
    if (rx_strobe === 1'b1) check("rx_bit", {23'h0, rx_bit}, {23'h0, reply & tx_sent});
  initial begin
    #30000;
    err_total++;
    wrap_up;
  end
  // main sequence
  initial begin
    seed = 82229;
    s = 3'($random(seed));
    int_group_map = 16'($random(seed));
    step(5);
    arst_n = 1;
    step(40);
    expect_pins(24'h7fff00, 24'h178000 | {9'h0, 7'h50 | {3'h0, s, 1'b0}, 8'h0});
    for (int k = 0; k < 4; k++) begin
      remote_enable_in_n[k] = 0;
      step(30);
      expect_pins(24'h0780f0, {5'h0, ~int_group_map[4*k +: 4], 15'h0});
      remote_enable_in_n = 4'hf;
      step(30);
      expect_pins(24'h0780f0, 24'h078000);
    end
    $display("remote enable test done");
    auto_turn_on = 0;
    soft_shutdown_in_n = 0;
    step(30);
    expect_pins(24'h7f8000, 24'h400000);
    soft_shutdown_in_n = 1;
    step(30);
    expect_pins(24'h7f8000, 24'h080000);
    auto_turn_on = 1;
    step(5);
    expect_pins(24'h7f8000, 24'h178000);
    soft_shutdown_in_n = 0;
    step(8);
    soft_shutdown_in_n = 1;
    step(30);
    expect_pins(24'h7f8000, 24'h178000);
    mains_fail_in_n = 0;
    step(30);
    expect_pins(24'h7f8000, 24'h400000);
    mains_fail_in_n = 1;
    step(30);
    expect_pins(24'h7f8000, 24'h178000);
    $display("shutdown pins test done");
    cold_reset_in_n = 0;
    s = ~s;
    step(30);
    expect_pins(24'h7f8000, 24'h080000);
    cold_reset_in_n = 1;
    step(40);
    expect_pins(24'h7fff00, 24'h178000 | {9'h0, 7'h50 | {3'h0, s, 1'b0}, 8'h0});
    ovp_threshold = {1'b0, 9'($random(seed))};
    bus_voltage_sense = ovp_threshold + 10'h1;
    step(1);
    bus_voltage_sense = ovp_threshold;
    step(2);
    expect_pins(24'h800000, 24'h800000);
    step(CB_PULSE_CYC + 5);
    expect_pins(24'h800000, 24'h0);
    group_force_off = 4'h4;
    step(5);
    expect_pins(24'h000004, 24'h000004);
    group_force_off = 0;
    ok_pull = 4'h2;
    step(30);
    expect_pins(24'h000020, 24'h000020);
    ok_pull = 0;
    ovp_threshold = 10'h3ff;
    repeat (6) begin
      tx_bit = 1'($random(seed));
      bus_voltage_sense = {1'b0, 9'($random(seed))};
      step(100);
    end
    $display("crowbar, ok line and sync test done");
    wrap_up;
  end
endmodule
bind pmc_top pmc_checker #(.CB_PULSE_CYC(CB_PULSE_CYC)) pmc_checker_inst (.clk, .arst_n,
  .mains_fail_in_n, .soft_shutdown_in_n, .bus_voltage_sense, .ovp_threshold, .group_force_off,
  .group_ok_line_out, .group_ok_line_oe, .sync_data_line_out, .sync_data_line_oe,
  .crowbar_trigger, .host_addr, .seq_state, .front_end_enable, .intermediate_bus_voltage);
`default_nettype wire
